// [hw/heat_seq_pkg.sv]
// constants shared by the heat sealing input sequencer
// assumes a 250 MHz sys_clk; every longer time is counted in 1 ms ticks
package heat_seq_pkg;
	// ============================================================
	// clock and time base
	localparam int CLK_PERIOD_NS  = 4;
	localparam int TICK_PERIOD_NS = 1000000;
	localparam int TICK_CYCLES    = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TICK_CNT_W     = 18;
	localparam int MS_W           = 16;

	// ============================================================
	// times in ms ticks, and the auto-zero try limit
	localparam logic [15:0] CAL_TIME_MS        = 16'h2EE0;
	localparam logic [15:0] INIT_BLOCK_MS      = 16'h2710;
	localparam logic [15:0] RESTART_DELAY_MS   = 16'h01F4;
	localparam logic [15:0] SUPPLY_DEADLINE_MS = 16'h00C8;
	localparam logic [15:0] SLOW_HALF_MS       = 16'h01F4;
	localparam logic [15:0] FAST_HALF_MS       = 16'h007D;
	localparam logic [1:0]  CAL_MAX_TRIES      = 2'h3;

	// ============================================================
	// limits
	localparam logic [8:0] MIN_HEAT_TEMP = 9'h028;
	localparam logic [6:0] MIN_POWER_PCT = 7'h05;
	localparam logic [5:0] MAX_BASE_TEMP = 6'h28;
	localparam logic [5:0] BASE_TEMP_RST = 6'h14;
	localparam logic [7:0] EXT_CAL_MIN   = 8'h03;
	localparam logic [7:0] EXT_CAL_MAX   = 8'h28;

	// ============================================================
	// error codes and groups
	localparam logic [9:0] ERR_CAL_UNSTABLE = 10'h072;
	localparam logic [9:0] ERR_EXT_HIGH     = 10'h073;
	localparam logic [9:0] ERR_EXT_FLUCT    = 10'h074;
	localparam logic [9:0] ERR_A_LO = 10'h065;
	localparam logic [9:0] ERR_A_HI = 10'h067;
	localparam logic [9:0] ERR_B_LO = 10'h0C9;
	localparam logic [9:0] ERR_B_HI = 10'h0CB;
	localparam logic [9:0] ERR_C_LO = 10'h384;
	localparam logic [9:0] ERR_C_HI = 10'h3E7;
	localparam logic [9:0] WRN_A_LO = 10'h068;
	localparam logic [9:0] WRN_A_HI = 10'h06A;
	localparam logic [9:0] WRN_B_LO = 10'h06F;
	localparam logic [9:0] WRN_B_HI = 10'h072;
	localparam logic [9:0] WRN_C    = 10'h0D3;
	localparam logic [9:0] WRN_D    = 10'h12E;
	localparam logic [9:0] WRN_E    = 10'h12F;

	// ============================================================
	// register map
	localparam int          ADDR_W      = 4;
	localparam int          DATA_W      = 32;
	localparam logic [3:0]  REG_CTRL    = 4'h0;
	localparam logic [3:0]  REG_DELAY   = 4'h4;
	localparam logic [3:0]  REG_STATUS  = 4'h8;
	localparam logic [3:0]  REG_ERROR   = 4'hC;
	localparam int          CTRL_BASE_W = 6;
	localparam int          CTRL_EXT    = 8;
	localparam int          CTRL_ZCAL   = 9;

	typedef enum {ST_IDLE, ST_CAL, ST_HEAT, ST_CPWR, ST_RESET, ST_INIT} seq_state_t;
endpackage: heat_seq_pkg

// [hw/timing_if.sv]
// millisecond tick and indicator blink phases
// assumes one producer and any number of readers on sys_clk
`timescale 1ns/1ps
interface timing_if;
	logic msTick;
	logic slowBlink;
	logic fastBlink;
	modport src(output msTick, output slowBlink, output fastBlink);
	modport dst(input msTick, input slowBlink, input fastBlink);
endinterface: timing_if

// [hw/time_base.sv]
// divider for the 1 ms tick and the 1 Hz / 4 Hz blink phases
// assumes sys_clk at the package rate
`timescale 1ns/1ps
module time_base #(
	parameter int TICK_CYCLES = heat_seq_pkg::TICK_CYCLES
) (
	input wire logic sys_clk,
	input wire logic resetn,
	timing_if.src    tb
);
	localparam int DW = heat_seq_pkg::TICK_CNT_W;
	localparam logic [DW-1:0] DIV_LAST = DW'(TICK_CYCLES - 1);

	logic [DW-1:0] divCnt;
	logic [15:0]   slowCnt;
	logic [15:0]   fastCnt;

	// ============================================================
	// tick
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			divCnt    <= '0;
			tb.msTick <= 1'b0;
		end else if (divCnt == DIV_LAST) begin
			divCnt    <= '0;
			tb.msTick <= 1'b1;
		end else begin
			divCnt    <= divCnt + 1'b1;
			tb.msTick <= 1'b0;
		end
	end

	// ============================================================
	// blink phases, toggled every half period
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			slowCnt      <= '0;
			fastCnt      <= '0;
			tb.slowBlink <= 1'b0;
			tb.fastBlink <= 1'b0;
		end else if (tb.msTick) begin
			if (slowCnt == heat_seq_pkg::SLOW_HALF_MS - 16'h0001) begin
				slowCnt      <= '0;
				tb.slowBlink <= !tb.slowBlink;
			end else begin
				slowCnt <= slowCnt + 16'h0001;
			end
			if (fastCnt == heat_seq_pkg::FAST_HALF_MS - 16'h0001) begin
				fastCnt      <= '0;
				tb.fastBlink <= !tb.fastBlink;
			end else begin
				fastCnt <= fastCnt + 16'h0001;
			end
		end
	end
endmodule: time_base

// [hw/cal_timer.sv]
// auto-zero run timer with repeat on element fluctuation
// assumes start is a one-cycle pulse given only while idle
`timescale 1ns/1ps
module cal_timer (
	input  wire logic sys_clk,
	input  wire logic resetn,
	timing_if.dst     tb,
	input  wire logic start,
	input  wire logic fluctuating,
	output logic      busy,
	output logic      done,
	output logic      failed
);
	logic [15:0] runCnt;
	logic [1:0]  tries;
	logic        sawFluct;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			busy     <= 1'b0;
			done     <= 1'b0;
			failed   <= 1'b0;
			runCnt   <= '0;
			tries    <= '0;
			sawFluct <= 1'b0;
		end else begin
			done   <= 1'b0;
			failed <= 1'b0;
			if (start && !busy) begin
				busy     <= 1'b1;
				runCnt   <= '0;
				tries    <= 2'h1;
				sawFluct <= 1'b0;
			end else if (busy) begin
				if (fluctuating)
					sawFluct <= 1'b1;
				if (tb.msTick) begin
					if (runCnt == heat_seq_pkg::CAL_TIME_MS - 16'h0001) begin
						runCnt <= '0;
						if (!(sawFluct || fluctuating)) begin
							busy <= 1'b0;
							done <= 1'b1;
						end else if (tries == heat_seq_pkg::CAL_MAX_TRIES) begin
							busy   <= 1'b0;
							failed <= 1'b1;
						end else begin
							tries    <= tries + 2'h1;
							sawFluct <= 1'b0;
						end
					end else begin
						runCnt <= runCnt + 16'h0001;
					end
				end
			end
		end
	end
endmodule: cal_timer

// [hw/heat_seq.sv]
// heat sealing controller input sequencer: auto-zero, start, reset, constant power
// assumes all request inputs and status inputs are synchronous levels on sys_clk
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ps
module heat_seq #(
	parameter int TICK_CYCLES = heat_seq_pkg::TICK_CYCLES
) (
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	input  wire logic [3:0]  regAddr,
	input  wire logic [31:0] regWrData,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	output logic      [31:0] regRdData,
	input  wire logic        autoZeroRequest,
	input  wire logic        startRequest,
	input  wire logic        resetRequest,
	input  wire logic        constantPowerRequest,
	input  wire logic [8:0]  tempSetpoint,
	input  wire logic [6:0]  powerSetpoint,
	input  wire logic [7:0]  calTempIn,
	input  wire logic        calTempUnstable,
	input  wire logic        elementFluctuating,
	input  wire logic        coolingFast,
	input  wire logic        lineVoltageOk,
	input  wire logic        supplyOk,
	input  wire logic [9:0]  errorIn,
	output logic             calLed,
	output logic             heatLed,
	output logic             constPowerLed,
	output logic             alarmOut,
	output logic             actualZero,
	output logic             heatEnable,
	output logic             constPowerEnable,
	output logic      [6:0]  powerLevel,
	output logic             measureEnable,
	output logic      [5:0]  calBaseTemp
);
	timing_if tb();

	heat_seq_pkg::seq_state_t state;
	logic        calStart;
	logic        calBusy;
	logic        calDone;
	logic        calFail;
	logic        prevAutoZero;
	logic        prevReset;
	logic        calPending;
	logic        powerUpSeen;
	logic        noLine;
	logic        everOk;
	logic        initWindow;
	logic [15:0] initCnt;
	logic [15:0] delayCnt;
	logic [15:0] supplyCnt;
	logic        supplyWatch;
	logic        lateSupply;
	logic        warnAlarm;
	logic [9:0]  errShown;
	logic [5:0]  baseTemp;
	logic        extCalMode;
	logic        zeroCalBit;
	logic [15:0] restartDelay;

	// ============================================================
	// helpers
	time_base #(.TICK_CYCLES(TICK_CYCLES)) u_time (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.tb      (tb.src)
	);

	cal_timer u_cal (
		.sys_clk     (sys_clk),
		.resetn      (resetn),
		.tb          (tb.dst),
		.start       (calStart),
		.fluctuating (elementFluctuating),
		.busy        (calBusy),
		.done        (calDone),
		.failed      (calFail)
	);

	// ============================================================
	// decoded conditions
	logic azReq;
	logic azEdge;
	logic resetRelease;
	logic grpA;
	logic grpB;
	logic grpC;
	logic errorPresent;
	logic warnPending;
	logic errBlock;
	logic calBlocked;
	logic extHigh;
	logic extBad;
	logic calGo;
	logic heatOk;
	logic cpwrOk;

	assign azReq        = autoZeroRequest || zeroCalBit;
	assign azEdge       = azReq && !prevAutoZero;
	assign resetRelease = prevReset && !resetRequest;
	assign grpA = (errorIn >= heat_seq_pkg::ERR_A_LO) && (errorIn <= heat_seq_pkg::ERR_A_HI);
	assign grpB = (errorIn >= heat_seq_pkg::ERR_B_LO) && (errorIn <= heat_seq_pkg::ERR_B_HI);
	assign grpC = (errorIn >= heat_seq_pkg::ERR_C_LO) && (errorIn <= heat_seq_pkg::ERR_C_HI);
	assign errorPresent = (errorIn != 10'h000) || (errShown != 10'h000);
	assign warnPending  = ((errorIn >= heat_seq_pkg::WRN_A_LO) && (errorIn <= heat_seq_pkg::WRN_A_HI))
		|| ((errorIn >= heat_seq_pkg::WRN_B_LO) && (errorIn <= heat_seq_pkg::WRN_B_HI))
		|| (errorIn == heat_seq_pkg::WRN_C) || (errorIn == heat_seq_pkg::WRN_D)
		|| (errorIn == heat_seq_pkg::WRN_E);
	assign errBlock = everOk ? (grpB || grpC) : (grpA || grpB || grpC);
	assign calBlocked = (initWindow && !errorPresent)
		|| coolingFast
		|| resetRequest
		|| errBlock
		|| noLine
		|| startRequest || constantPowerRequest
		|| (state != heat_seq_pkg::ST_IDLE);
	assign extHigh = calTempIn > heat_seq_pkg::EXT_CAL_MAX;
	assign extBad  = extCalMode && (extHigh || calTempUnstable);
	assign calGo   = calPending && !calBlocked && !extBad;
	assign heatOk  = (tempSetpoint > heat_seq_pkg::MIN_HEAT_TEMP) && !warnPending;
	assign cpwrOk  = (powerSetpoint > heat_seq_pkg::MIN_POWER_PCT) && !warnPending;

	// ============================================================
	// input edges
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			prevAutoZero <= 1'b0;
			prevReset    <= 1'b0;
		end else begin
			prevAutoZero <= azReq;
			prevReset    <= resetRequest;
		end
	end

	// ============================================================
	// auto-zero request latch: kept while the level stays high
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			calPending <= 1'b0;
			calStart   <= 1'b0;
		end else begin
			calStart <= calGo;
			if (azEdge)
				calPending <= 1'b1;
			else if (calGo || (calPending && !calBlocked && extBad))
				calPending <= 1'b0;
			else if (calBlocked && !azReq)
				calPending <= 1'b0;
		end
	end

	// ============================================================
	// line voltage caught once after power-on
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			powerUpSeen <= 1'b0;
			noLine      <= 1'b0;
		end else if (!powerUpSeen) begin
			powerUpSeen <= 1'b1;
			noLine      <= !lineVoltageOk;
		end
	end

	// ============================================================
	// ten second window after power-on or reset release
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			initWindow <= 1'b1;
			initCnt    <= '0;
		end else if (resetRelease) begin
			initWindow <= 1'b1;
			initCnt    <= '0;
		end else if (initWindow && tb.msTick) begin
			if (initCnt == heat_seq_pkg::INIT_BLOCK_MS - 16'h0001)
				initWindow <= 1'b0;
			else
				initCnt <= initCnt + 16'h0001;
		end
	end

	// ============================================================
	// supply deadline after reset release
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			supplyWatch <= 1'b0;
			supplyCnt   <= '0;
			lateSupply  <= 1'b0;
		end else if (resetRelease) begin
			supplyWatch <= 1'b1;
			supplyCnt   <= '0;
			lateSupply  <= 1'b0;
		end else if (supplyWatch) begin
			if (supplyOk) begin
				supplyWatch <= 1'b0;
			end else if (tb.msTick) begin
				if (supplyCnt == heat_seq_pkg::SUPPLY_DEADLINE_MS - 16'h0001) begin
					supplyWatch <= 1'b0;
					lateSupply  <= 1'b1;
				end else begin
					supplyCnt <= supplyCnt + 16'h0001;
				end
			end
		end
	end

	// ============================================================
	// sequencer
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state    <= heat_seq_pkg::ST_IDLE;
			delayCnt <= '0;
		end else begin
			unique case (state)
				heat_seq_pkg::ST_IDLE: begin
					if (resetRequest)
						state <= heat_seq_pkg::ST_RESET;
					else if (calGo)
						state <= heat_seq_pkg::ST_CAL;
					else if (startRequest && heatOk)
						state <= heat_seq_pkg::ST_HEAT;
					else if (!startRequest && constantPowerRequest && cpwrOk)
						state <= heat_seq_pkg::ST_CPWR;
				end
				heat_seq_pkg::ST_CAL: begin
					// reset only takes effect once the run has ended
					if ((calDone || calFail) && resetRequest)
						state <= heat_seq_pkg::ST_RESET;
					else if (calDone || calFail)
						state <= heat_seq_pkg::ST_IDLE;
				end
				heat_seq_pkg::ST_HEAT: begin
					if (resetRequest)
						state <= heat_seq_pkg::ST_RESET;
					else if (!startRequest)
						state <= heat_seq_pkg::ST_IDLE;
				end
				heat_seq_pkg::ST_CPWR: begin
					if (resetRequest)
						state <= heat_seq_pkg::ST_RESET;
					else if (!constantPowerRequest)
						state <= heat_seq_pkg::ST_IDLE;
				end
				heat_seq_pkg::ST_RESET: begin
					delayCnt <= '0;
					if (!resetRequest)
						state <= heat_seq_pkg::ST_INIT;
				end
				heat_seq_pkg::ST_INIT: begin
					if (resetRequest) begin
						state <= heat_seq_pkg::ST_RESET;
					end else if (tb.msTick) begin
						if (delayCnt + 16'h0001 >= restartDelay)
							state <= heat_seq_pkg::ST_IDLE;
						else
							delayCnt <= delayCnt + 16'h0001;
					end
				end
			endcase
		end
	end

	// ============================================================
	// error display and history
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			errShown <= '0;
		end else begin
			if (resetRelease)
				errShown <= '0;
			if (calFail)
				errShown <= heat_seq_pkg::ERR_CAL_UNSTABLE;
			else if (calPending && !calBlocked && extCalMode && extHigh)
				errShown <= heat_seq_pkg::ERR_EXT_HIGH;
			else if (calPending && !calBlocked && extCalMode && calTempUnstable)
				errShown <= heat_seq_pkg::ERR_EXT_FLUCT;
			else if (errorIn != 10'h000 && errShown == 10'h000)
				errShown <= errorIn;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			everOk <= 1'b0;
		else if (calDone || (state == heat_seq_pkg::ST_HEAT && errorIn == 10'h000))
			everOk <= 1'b1;
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			warnAlarm <= 1'b0;
		else if (warnPending && state == heat_seq_pkg::ST_IDLE && (startRequest || constantPowerRequest))
			warnAlarm <= 1'b1;
		else if (!startRequest && !constantPowerRequest)
			warnAlarm <= 1'b0;
	end

	// ============================================================
	// register port
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			baseTemp     <= heat_seq_pkg::BASE_TEMP_RST;
			extCalMode   <= 1'b0;
			zeroCalBit   <= 1'b0;
			restartDelay <= heat_seq_pkg::RESTART_DELAY_MS;
		end else if (regWrite) begin
			if (regAddr == heat_seq_pkg::REG_CTRL) begin
				if (regWrData[5:0] > heat_seq_pkg::MAX_BASE_TEMP)
					baseTemp <= heat_seq_pkg::MAX_BASE_TEMP;
				else
					baseTemp <= regWrData[5:0];
				extCalMode <= regWrData[heat_seq_pkg::CTRL_EXT];
				zeroCalBit <= regWrData[heat_seq_pkg::CTRL_ZCAL];
			end
			if (regAddr == heat_seq_pkg::REG_DELAY)
				restartDelay <= regWrData[15:0];
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			regRdData <= '0;
		end else if (regRead) begin
			unique case (regAddr)
				heat_seq_pkg::REG_CTRL:
					regRdData <= {22'h000000, zeroCalBit, extCalMode, 2'h0, baseTemp};
				heat_seq_pkg::REG_DELAY:
					regRdData <= {16'h0000, restartDelay};
				heat_seq_pkg::REG_STATUS:
					regRdData <= {21'h000000, initWindow, lateSupply, everOk, noLine, calBlocked, calPending,
						state == heat_seq_pkg::ST_INIT, state == heat_seq_pkg::ST_RESET,
						state == heat_seq_pkg::ST_CPWR, state == heat_seq_pkg::ST_HEAT, calBusy};
				heat_seq_pkg::REG_ERROR:
					regRdData <= {22'h000000, errShown};
				default:
					regRdData <= '0;
			endcase
		end else begin
			regRdData <= '0;
		end
	end

	// ============================================================
	// lamps and drive outputs
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			calLed        <= 1'b0;
			heatLed       <= 1'b0;
			constPowerLed <= 1'b0;
		end else begin
			if (state == heat_seq_pkg::ST_CAL)
				calLed <= 1'b1;
			else if (calPending && calBlocked)
				calLed <= tb.fastBlink;
			else if (resetRequest || noLine)
				calLed <= tb.slowBlink;
			else
				calLed <= 1'b0;
			if (state == heat_seq_pkg::ST_HEAT)
				heatLed <= 1'b1;
			else if (startRequest)
				heatLed <= tb.fastBlink;
			else
				heatLed <= 1'b0;
			if (state == heat_seq_pkg::ST_CPWR)
				constPowerLed <= 1'b1;
			else if (constantPowerRequest)
				constPowerLed <= tb.fastBlink;
			else
				constPowerLed <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			alarmOut         <= 1'b0;
			actualZero       <= 1'b0;
			heatEnable       <= 1'b0;
			constPowerEnable <= 1'b0;
			powerLevel       <= '0;
			measureEnable    <= 1'b0;
			calBaseTemp      <= heat_seq_pkg::BASE_TEMP_RST;
		end else begin
			alarmOut   <= (errShown != 10'h000) || warnAlarm || lateSupply;
			actualZero <= (state == heat_seq_pkg::ST_CAL) || resetRequest;
			heatEnable <= state == heat_seq_pkg::ST_HEAT;
			constPowerEnable <= state == heat_seq_pkg::ST_CPWR;
			powerLevel <= (state == heat_seq_pkg::ST_CPWR) ? powerSetpoint : 7'h00;
			measureEnable <= state != heat_seq_pkg::ST_RESET;
			if (extCalMode && calTempIn >= heat_seq_pkg::EXT_CAL_MIN && !extHigh)
				calBaseTemp <= calTempIn[5:0];
			else if (!extCalMode)
				calBaseTemp <= baseTemp;
		end
	end
endmodule: heat_seq

// [testbench/heat_seq_assertions.sv]
// port checker for the heat sequencer
// assumes a bind onto heat_seq, one clock domain
`timescale 1ns/1ps
module heat_seq_assertions #(
	parameter int TICK_CYCLES = heat_seq_pkg::TICK_CYCLES
) (
	input wire logic       sys_clk,
	input wire logic       resetn,
	input wire logic       resetRequest,
	input wire logic [8:0] tempSetpoint,
	input wire logic [6:0] powerSetpoint,
	input wire logic       heatEnable,
	input wire logic       heatLed,
	input wire logic       constPowerEnable,
	input wire logic       constPowerLed,
	input wire logic [6:0] powerLevel,
	input wire logic       actualZero,
	input wire logic       measureEnable
);
	// ========
	// properties
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	a_heat_needs_temp: assert property ($rose(heatEnable) |->
		$past(tempSetpoint, 2) > heat_seq_pkg::MIN_HEAT_TEMP) else $error("heat on with low setpoint");
	a_cpwr_needs_power: assert property ($rose(constPowerEnable) |->
		$past(powerSetpoint, 2) > heat_seq_pkg::MIN_POWER_PCT) else $error("power on with low setpoint");
	a_cpwr_led_level: assert property (constPowerEnable |-> constPowerLed && powerLevel != 7'h00)
		else $error("constant power without lamp or level");
	a_level_idle_zero: assert property (!constPowerEnable |-> powerLevel == 7'h00)
		else $error("power level outside constant power");
	a_heat_led_on: assert property (heatEnable |-> heatLed)
		else $error("heating without lamp");
	a_reset_stops_all: assert property (resetRequest [*4] |-> !heatEnable && !constPowerEnable)
		else $error("heating while reset held");
	a_restart_no_heat: assert property ($fell(resetRequest) |=> !heatEnable [*8])
		else $error("heating inside restart delay");
	a_reset_zero_out: assert property ($past(resetRequest) |-> actualZero)
		else $error("actual output not zero in reset");
	c_heat: cover property ($rose(heatEnable));
	c_cpwr: cover property ($rose(constPowerEnable));
	c_reset: cover property ($fell(resetRequest));
endmodule: heat_seq_assertions

bind heat_seq heat_seq_assertions #(.TICK_CYCLES(TICK_CYCLES)) i_chk (
	.sys_clk(sys_clk), .resetn(resetn), .resetRequest(resetRequest),
	.tempSetpoint(tempSetpoint), .powerSetpoint(powerSetpoint), .heatEnable(heatEnable),
	.heatLed(heatLed), .constPowerEnable(constPowerEnable), .constPowerLed(constPowerLed),
	.powerLevel(powerLevel), .actualZero(actualZero), .measureEnable(measureEnable)
);

// [testbench/plc_supply.sv]
// machine controller model: control circuit power switch
// assumes one ms is MS_CYC cycles of sys_clk
`timescale 1ns/1ps
module plc_supply #(
	parameter int MS_CYC = 2
) (
	input  wire logic sys_clk,
	input  wire logic resetn,
	input  wire logic resetRequest,
	input  wire logic lateMode,
	output logic      supplyOk
);
	int cnt;
	// ========
	// switch opens in reset, closes 10 ms after release or 300 ms when late
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cnt <= 0;
			supplyOk <= 1'b1;
		end else if (resetRequest) begin
			cnt <= 0;
			supplyOk <= 1'b0;
		end else if (!supplyOk) begin
			cnt <= cnt + 1;
			supplyOk <= cnt >= (lateMode ? 300 : 10) * MS_CYC;
		end
	end
endmodule: plc_supply

// [testbench/tb_top.sv]
// self-checking bench for the heat sequencer
// assumes design package, checker and supply model compiled first
`timescale 1ns/1ps
module tb_top;
	localparam int TK = 2;
	logic        sys_clk = 1'b0;
	logic        resetn = 1'b0;
	logic [3:0]  regAddr = 4'h0;
	logic [31:0] regWrData = 32'h0;
	logic        regWrite = 1'b0;
	logic        regRead = 1'b0;
	logic        autoZeroRequest = 1'b0;
	logic        startRequest = 1'b0;
	logic        resetRequest = 1'b0;
	logic        constPowerRequest = 1'b0;
	logic        coolingFast = 1'b0;
	logic        lateMode = 1'b0;
	logic [8:0]  tempSetpoint = 9'h064;
	logic [6:0]  powerSetpoint = 7'h32;
	logic [9:0]  errorIn = 10'h000;
	logic [31:0] regRdData;
	logic [6:0]  powerLevel;
	logic        supplyOk, calLed, heatLed, constPowerLed, alarmOut, actualZero, heatEnable, constPowerEnable;
	logic        measureEnable;
	logic [5:0]  calBaseTemp;
	int          errCount = 0;
	int          testsRun = 0;

	heat_seq #(.TICK_CYCLES(TK)) i_dut (
		.sys_clk(sys_clk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
		.regRead(regRead), .regRdData(regRdData), .autoZeroRequest(autoZeroRequest),
		.startRequest(startRequest), .resetRequest(resetRequest), .constantPowerRequest(constPowerRequest),
		.tempSetpoint(tempSetpoint), .powerSetpoint(powerSetpoint), .calTempIn(8'h14),
		.calTempUnstable(1'b0), .elementFluctuating(1'b0), .coolingFast(coolingFast), .lineVoltageOk(1'b1),
		.supplyOk(supplyOk), .errorIn(errorIn), .calLed(calLed), .heatLed(heatLed),
		.constPowerLed(constPowerLed), .alarmOut(alarmOut), .actualZero(actualZero), .heatEnable(heatEnable),
		.constPowerEnable(constPowerEnable), .powerLevel(powerLevel), .measureEnable(measureEnable),
		.calBaseTemp(calBaseTemp)
	);
	plc_supply #(.MS_CYC(TK)) i_plc (
		.sys_clk(sys_clk), .resetn(resetn), .resetRequest(resetRequest), .lateMode(lateMode), .supplyOk(supplyOk)
	);

	always #2 sys_clk = ~sys_clk;

	// ========
	// helpers
	task cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask: cyc
	task look(input int n);
		cyc(n);
		#1;
	endtask: look
	task chk(input logic [31:0] got, input logic [31:0] exp);
		testsRun++;
		if (got !== exp) begin
			errCount++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask: chk
	task wr(input logic [3:0] a, input logic [31:0] d);
		cyc(1);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		cyc(1);
		regWrite <= 1'b0;
	endtask: wr
	task rd(input logic [3:0] a, input logic [31:0] e);
		cyc(1);
		regAddr <= a;
		regRead <= 1'b1;
		cyc(1);
		regRead <= 1'b0;
		#1;
		chk(regRdData, e);
	endtask: rd
	task conclude;
		$display("checks %0d mismatches %0d", testsRun, errCount);
		if (errCount == 0 && testsRun > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask: conclude

	// ========
	// scenarios
	task t_heat;
		cyc(1);
		autoZeroRequest <= 1'b1;
		startRequest <= 1'b1;
		look(6);
		chk({actualZero, heatEnable, heatLed}, 3'h3);
		chk(calBaseTemp, 6'h14);
		cyc(1);
		{autoZeroRequest, startRequest, tempSetpoint} <= {2'h0, 9'h028};
		cyc(2);
		startRequest <= 1'b1;
		look(4);
		chk(heatEnable, 1'b0);
		cyc(1);
		{startRequest, tempSetpoint, constPowerRequest} <= {1'b0, 9'h064, 1'b1};
		look(4);
		chk({constPowerEnable, constPowerLed, powerLevel}, {2'h3, 7'h32});
		cyc(1);
		{constPowerRequest, powerSetpoint} <= {1'b0, 7'h05};
		cyc(2);
		constPowerRequest <= 1'b1;
		look(4);
		chk(constPowerEnable, 1'b0);
		cyc(1);
		{constPowerRequest, powerSetpoint} <= {1'b0, 7'h32};
	endtask: t_heat
	task t_cal;
		int n;
		logic [1:0] blink;
		cyc(10100 * TK);
		{coolingFast, autoZeroRequest} <= 2'h3;
		blink = 2'h0;
		// a blocked request must show both lamp phases within one fast blink period
		repeat (300) begin
			look(1);
			blink = blink | {calLed, !calLed};
		end
		chk(blink, 2'h3);
		chk(actualZero, 1'b0);
		cyc(1);
		coolingFast <= 1'b0;
		look(4);
		chk({actualZero, calLed}, 2'h3);
		cyc(1);
		{startRequest, resetRequest, autoZeroRequest} <= 3'h6;
		look(8);
		chk({heatEnable, calLed, actualZero, measureEnable}, 4'h7);
		cyc(1);
		{startRequest, resetRequest} <= 2'h0;
		n = 14;
		while (actualZero === 1'b1 && n < 40000) begin
			look(1);
			n++;
		end
		chk(n >= 10000 * TK && n <= 15000 * TK, 1'b1);
	endtask: t_cal
	task t_reset;
		cyc(1);
		{errorIn, startRequest} <= {heat_seq_pkg::WRN_C, 1'b1};
		look(4);
		chk({alarmOut, heatEnable}, 2'h2);
		cyc(1);
		{errorIn, startRequest} <= 11'h0;
		rd(heat_seq_pkg::REG_DELAY, 32'h1F4);
		wr(heat_seq_pkg::REG_DELAY, 32'h14);
		rd(4'h2, 32'h0);
		wr(heat_seq_pkg::REG_CTRL, 32'h3F);
		rd(heat_seq_pkg::REG_CTRL, 32'h28);
		chk(calBaseTemp, 6'h28);
		cyc(1);
		{resetRequest, startRequest} <= 2'h3;
		look(4);
		chk({measureEnable, actualZero, heatEnable}, 3'h2);
		rd(heat_seq_pkg::REG_ERROR, 32'h0D3);
		cyc(1);
		{resetRequest, startRequest} <= 2'h0;
		rd(heat_seq_pkg::REG_ERROR, 32'h0);
		cyc(1);
		startRequest <= 1'b1;
		look(4);
		chk(heatEnable, 1'b0);
		cyc(21 * TK);
		look(4);
		chk(heatEnable, 1'b1);
		cyc(1);
		{startRequest, lateMode, resetRequest} <= 3'h3;
		cyc(4);
		resetRequest <= 1'b0;
		look(250 * TK);
		chk(alarmOut, 1'b1);
	endtask: t_reset

	initial begin
		cyc(6);
		resetn <= 1'b1;
		cyc(2);
		t_heat();
		t_cal();
		t_reset();
		conclude();
	end
	initial begin
		cyc(90000);
		errCount++;
		conclude();
	end
endmodule: tb_top
